// File: rtl/fisp_pins_if.sv
`timescale 1ns/1ps
interface fisp_pins_if;
  logic [fisp_pkg::PIN_W-1:0] raw;
  logic [fisp_pkg::PIN_W-1:0] filt;
  modport filt_side (input raw, output filt);
  modport core_side (output raw, input filt);
endinterface

// File: rtl/fisp_pkg.sv
package fisp_pkg;
  localparam int CLK_MHZ = 100;
  // pin group order inside the synchroniser
  localparam int PIN_W = 3;
  localparam int PIN_CS = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 0;
  localparam logic [2:0] PIN_IDLE = 3'h4;
  // opcodes
  localparam logic [7:0] OP_JEDEC_ID = 8'h9f;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_PDN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_ID = 8'hab;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  // security area
  localparam int SEC_BYTES = 512;
  localparam logic [8:0] SEC_LAST = 9'h1ff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] JEDEC_LAST = 4'h2;
  // timing, figures as printed
  localparam int T_PDN_NS = 100;
  localparam int T_REL_NS = 100;
  localparam int T_PP_US = 1400;
  localparam int T_SE_US = 120000;
  localparam int PDN_CYC = (T_PDN_NS * CLK_MHZ / 1000 < 1) ? 1 : T_PDN_NS * CLK_MHZ / 1000;
  localparam int REL_CYC = (T_REL_NS * CLK_MHZ / 1000 < 1) ? 1 : T_REL_NS * CLK_MHZ / 1000;
  localparam int PP_CYC = T_PP_US * CLK_MHZ;
  localparam int SE_CYC = T_SE_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUM = 3'b011,
    ST_DATA = 3'b100,
    ST_OUT = 3'b101,
    ST_IGN = 3'b110
  } fisp_state_t;
  typedef enum logic [1:0] {
    CY_NONE = 2'b00,
    CY_ERASE = 2'b01,
    CY_PROG = 2'b10
  } fisp_cycle_t;
endpackage

// File: rtl/fisp_sync.sv
`timescale 1ns/1ps
module fisp_sync #(
  parameter int W = fisp_pkg::PIN_W,
  parameter logic [W-1:0] INIT = fisp_pkg::PIN_IDLE
) (
  input wire logic mclk,
  input wire logic rstn,
  fisp_pins_if.filt_side pins
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] filt_q;
  logic [W-1:0] filt_d;

  if (W != fisp_pkg::PIN_W) begin : g_bad_width
    $error("synchroniser width must match the pin group");
  end

  // a bit moves only once stages two and three agree, so a one-cycle glitch dies here
  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      filt_q <= INIT;
    end else begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign pins.filt = filt_q;
endmodule

// File: rtl/fisp_top.sv
`timescale 1ns/1ps
// Function
// - 9fh shifts maker, type, capacity bytes
// - identity read not decoded while busy
// - output on falling edges; deselect ends read
// - 4bh, address, dummy, then 128-bit identifier
// - 44h erases 512-byte area, latch required
// - erase runs only on exact deselect
// - busy flag during cycle; latch cleared
// - lock bit blocks area erase and program
// - 42h, address, data bytes, latch required
// - deselect after a full 42h data byte starts program cycle
// - 48h, address, dummy, then incrementing data
// - read address wraps 1ffh to 000h
// - b9h exact, entry delay, then power-down
// - power-down ignores all but release
// - power-down command rejected while busy
// - deselect gives standby, not power-down
// - reset always starts in standby
// - abh deselect releases at once, then release delay blocks decode
// - abh with dummies repeats device id
// - abh ignored while busy
// - entry and release delays 0.1 us
module fisp_top #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h33, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h14, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h13, // arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, // arbitrary
  parameter int PP_CYCLES = fisp_pkg::PP_CYC,
  parameter int SE_CYCLES = fisp_pkg::SE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic security_lock_bit,
  output logic write_in_progress,
  output logic write_enable_latch,
  output logic deep_power_down
);
  localparam int PDW = fisp_pkg::PDN_CYC;

  if (PP_CYCLES < 1 || SE_CYCLES < 1) begin : g_bad_cycles
    $error("busy cycle counts must be at least one");
  end
  if (fisp_pkg::PDN_CYC > 255 || fisp_pkg::REL_CYC > 255) begin : g_bad_delay
    $error("power-down delays exceed the 8-bit counters");
  end

  fisp_pins_if pins ();
  assign pins.raw = {spi_cs_n, spi_sck, spi_si};

  fisp_sync #(
    .W(fisp_pkg::PIN_W),
    .INIT(fisp_pkg::PIN_IDLE)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pins(pins)
  );

  logic cs_f;
  logic sck_f;
  logic si_f;
  assign cs_f = pins.filt[fisp_pkg::PIN_CS];
  assign sck_f = pins.filt[fisp_pkg::PIN_SCK];
  assign si_f = pins.filt[fisp_pkg::PIN_SI];

  // link state
  fisp_pkg::fisp_state_t state_q, state_d, st, dec_st;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] opc_q, opc_d;
  logic [23:0] addr_q, addr_d;
  logic [7:0] osh_q, osh_d;
  logic [2:0] obit_q, obit_d;
  logic [3:0] oidx_q, oidx_d, nidx;
  logic so_q, so_d;
  logic oe_q, oe_d;
  logic prog_ok_q, prog_ok_d;
  logic prog_any_q, prog_any_d;
  logic sck_p_q;
  logic cs_p_q;
  logic [7:0] mem_q [fisp_pkg::SEC_BYTES];
  logic [7:0] mem_d [fisp_pkg::SEC_BYTES];
  // control state
  fisp_pkg::fisp_cycle_t cy_q, cy_d;
  logic [31:0] busy_cnt_q, busy_cnt_d;
  logic wr_latch_q, wr_latch_d;
  logic pd_q, pd_d;
  logic [7:0] pdn_cnt_q, pdn_cnt_d;
  logic [7:0] rel_cnt_q, rel_cnt_d;
  // events and helpers
  logic sck_rise, sck_fall, cs_rise;
  logic [7:0] bit_in;
  logic busy, pd_any, cmd_exact, cmd_done, erase_done;
  logic ev_wr_enable, ev_pdn, ev_rel, ev_erase, ev_prog;

  assign sck_rise = sck_f && !sck_p_q && !cs_f;
  assign sck_fall = !sck_f && sck_p_q && !cs_f;
  assign cs_rise = cs_f && !cs_p_q;
  assign bit_in = {sh_q[6:0], si_f};
  assign busy = cy_q != fisp_pkg::CY_NONE;
  // an entry still in flight already counts as power-down for decoding
  assign pd_any = pd_q || pdn_cnt_q != 8'h00;
  assign st = (state_q == fisp_pkg::ST_IDLE) ? fisp_pkg::ST_CMD : state_q;
  assign cmd_exact = state_q == fisp_pkg::ST_ADDR && cnt_q == 5'h00;
  assign cmd_done = sck_rise && st == fisp_pkg::ST_CMD && cnt_q == 5'h07;
  assign erase_done = cy_q == fisp_pkg::CY_ERASE && busy_cnt_q == 32'h1;
  assign nidx = (opc_q == fisp_pkg::OP_JEDEC_ID && oidx_q == fisp_pkg::JEDEC_LAST) ?
                4'h0 : oidx_q + 4'h1;

  function automatic logic [7:0] out_byte(input logic [7:0] op, input logic [3:0] idx,
                                          input logic [7:0] mb);
    logic [7:0] b;
    b = mb;
    case (op)
      fisp_pkg::OP_JEDEC_ID: begin
        b = (idx == 4'h0) ? MAKER_CODE : (idx == 4'h1) ? MEM_TYPE : CAPACITY;
      end
      fisp_pkg::OP_UNIQUE_ID: begin
        b = UNIQUE_ID[8 * (4'hf - idx) +: 8];
      end
      fisp_pkg::OP_RELEASE_ID: begin
        b = DEVICE_ID;
      end
      default: begin
        b = mb;
      end
    endcase
    return b;
  endfunction

  // command decode, taken at the eighth opcode bit
  always_comb begin
    dec_st = fisp_pkg::ST_IGN;
    if (rel_cnt_q != 8'h00) begin
      dec_st = fisp_pkg::ST_IGN;
    end else if (pd_any) begin
      if (bit_in == fisp_pkg::OP_RELEASE_ID) begin
        dec_st = fisp_pkg::ST_ADDR;
      end
    end else begin
      case (bit_in)
        fisp_pkg::OP_JEDEC_ID: begin
          dec_st = busy ? fisp_pkg::ST_IGN : fisp_pkg::ST_OUT;
        end
        fisp_pkg::OP_UNIQUE_ID, fisp_pkg::OP_SEC_READ: begin
          dec_st = busy ? fisp_pkg::ST_IGN : fisp_pkg::ST_ADDR;
        end
        fisp_pkg::OP_SEC_ERASE, fisp_pkg::OP_SEC_PROG: begin
          if (!busy && wr_latch_q && !security_lock_bit) begin
            dec_st = fisp_pkg::ST_ADDR;
          end
        end
        fisp_pkg::OP_PDN, fisp_pkg::OP_WR_ENABLE, fisp_pkg::OP_RELEASE_ID: begin
          dec_st = busy ? fisp_pkg::ST_IGN : fisp_pkg::ST_ADDR;
        end
        default: begin
          dec_st = fisp_pkg::ST_IGN;
        end
      endcase
    end
  end

  // link: shifting, output and the security area
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    opc_d = opc_q;
    addr_d = addr_q;
    osh_d = osh_q;
    obit_d = obit_q;
    oidx_d = oidx_q;
    so_d = so_q;
    oe_d = oe_q;
    prog_ok_d = prog_ok_q;
    prog_any_d = prog_any_q;
    mem_d = mem_q;
    ev_wr_enable = 1'b0;
    ev_pdn = 1'b0;
    ev_rel = 1'b0;
    ev_erase = 1'b0;
    ev_prog = 1'b0;
    if (erase_done) begin
      for (int i = 0; i < fisp_pkg::SEC_BYTES; i++) begin
        mem_d[i] = fisp_pkg::ERASED_BYTE;
      end
    end
    if (cs_f) begin
      state_d = fisp_pkg::ST_IDLE;
      cnt_d = 5'h00;
      oe_d = 1'b0;
      prog_ok_d = 1'b0;
      prog_any_d = 1'b0;
      if (cs_rise) begin
        ev_wr_enable = opc_q == fisp_pkg::OP_WR_ENABLE && cmd_exact;
        ev_pdn = opc_q == fisp_pkg::OP_PDN && cmd_exact && !busy;
        ev_rel = opc_q == fisp_pkg::OP_RELEASE_ID && pd_q &&
                 (state_q == fisp_pkg::ST_ADDR || state_q == fisp_pkg::ST_OUT);
        ev_erase = opc_q == fisp_pkg::OP_SEC_ERASE && state_q == fisp_pkg::ST_DUM;
        ev_prog = opc_q == fisp_pkg::OP_SEC_PROG && prog_any_q;
      end
    end else if (sck_rise) begin
      state_d = st;
      case (st)
        fisp_pkg::ST_CMD: begin
          sh_d = bit_in;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h07) begin
            opc_d = bit_in;
            cnt_d = 5'h00;
            state_d = dec_st;
            osh_d = out_byte(bit_in, 4'h0, 8'h00);
            oidx_d = 4'h0;
            obit_d = 3'h0;
            prog_ok_d = bit_in == fisp_pkg::OP_SEC_PROG;
          end
        end
        fisp_pkg::ST_ADDR: begin
          addr_d = {addr_q[22:0], si_f};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h17) begin
            cnt_d = 5'h00;
            case (opc_q)
              fisp_pkg::OP_SEC_ERASE, fisp_pkg::OP_SEC_READ, fisp_pkg::OP_UNIQUE_ID: begin
                state_d = fisp_pkg::ST_DUM;
              end
              fisp_pkg::OP_SEC_PROG: begin
                state_d = fisp_pkg::ST_DATA;
              end
              fisp_pkg::OP_RELEASE_ID: begin
                state_d = fisp_pkg::ST_OUT;
              end
              default: begin
                state_d = fisp_pkg::ST_IGN;
              end
            endcase
          end
        end
        fisp_pkg::ST_DUM: begin
          cnt_d = cnt_q + 5'h01;
          if (opc_q == fisp_pkg::OP_SEC_ERASE) begin
            state_d = fisp_pkg::ST_IGN;
          end else if (cnt_q == 5'h07) begin
            state_d = fisp_pkg::ST_OUT;
            if (opc_q == fisp_pkg::OP_SEC_READ) begin
              // only the low nine address bits select a byte; the rest are the host's zeros
              osh_d = mem_q[addr_q[8:0]];
              addr_d = {addr_q[23:9], addr_q[8:0] + 9'h001};
            end
          end
        end
        fisp_pkg::ST_DATA: begin
          sh_d = bit_in;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h07) begin
            cnt_d = 5'h00;
            if (prog_ok_q) begin
              // programming only clears bits, as in the cell
              mem_d[addr_q[8:0]] = mem_q[addr_q[8:0]] & bit_in;
              prog_any_d = 1'b1;
              addr_d = {addr_q[23:9], addr_q[8:0] + 9'h001};
            end
          end
        end
        default: begin
          cnt_d = cnt_q;
        end
      endcase
    end else if (sck_fall && state_q == fisp_pkg::ST_OUT) begin
      so_d = osh_q[7];
      oe_d = 1'b1;
      obit_d = obit_q + 3'h1;
      osh_d = {osh_q[6:0], 1'b0};
      if (obit_q == 3'h7) begin
        oidx_d = nidx;
        osh_d = out_byte(opc_q, nidx, mem_q[addr_q[8:0]]);
        if (opc_q == fisp_pkg::OP_SEC_READ) begin
          addr_d = {addr_q[23:9], addr_q[8:0] + 9'h001};
        end
      end
    end
  end

  // self-timed cycles, write latch and power-down
  always_comb begin
    cy_d = cy_q;
    busy_cnt_d = busy_cnt_q;
    wr_latch_d = wr_latch_q;
    pd_d = pd_q;
    pdn_cnt_d = pdn_cnt_q;
    rel_cnt_d = rel_cnt_q;
    if (busy_cnt_q != 32'h0) begin
      busy_cnt_d = busy_cnt_q - 32'h1;
      if (busy_cnt_q == 32'h1) begin
        cy_d = fisp_pkg::CY_NONE;
      end
    end
    if (pdn_cnt_q != 8'h00) begin
      pdn_cnt_d = pdn_cnt_q - 8'h01;
      if (pdn_cnt_q == 8'h01) begin
        pd_d = 1'b1;
      end
    end
    if (rel_cnt_q != 8'h00) begin
      rel_cnt_d = rel_cnt_q - 8'h01;
    end
    if (ev_wr_enable) begin
      wr_latch_d = 1'b1;
    end
    if (ev_erase) begin
      cy_d = fisp_pkg::CY_ERASE;
      busy_cnt_d = 32'(SE_CYCLES);
      wr_latch_d = 1'b0;
    end
    if (ev_prog) begin
      cy_d = fisp_pkg::CY_PROG;
      busy_cnt_d = 32'(PP_CYCLES);
      wr_latch_d = 1'b0;
    end
    if (ev_pdn) begin
      pdn_cnt_d = 8'(fisp_pkg::PDN_CYC);
    end
    if (ev_rel) begin
      pd_d = 1'b0;
      rel_cnt_d = 8'(fisp_pkg::REL_CYC);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= fisp_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 8'h00;
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      osh_q <= 8'h00;
      obit_q <= 3'h0;
      oidx_q <= 4'h0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      prog_ok_q <= 1'b0;
      prog_any_q <= 1'b0;
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      for (int i = 0; i < fisp_pkg::SEC_BYTES; i++) begin
        mem_q[i] <= fisp_pkg::ERASED_BYTE;
      end
      cy_q <= fisp_pkg::CY_NONE;
      busy_cnt_q <= 32'h0;
      wr_latch_q <= 1'b0;
      pd_q <= 1'b0;
      pdn_cnt_q <= 8'h00;
      rel_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      osh_q <= osh_d;
      obit_q <= obit_d;
      oidx_q <= oidx_d;
      so_q <= so_d;
      oe_q <= oe_d;
      prog_ok_q <= prog_ok_d;
      prog_any_q <= prog_any_d;
      sck_p_q <= sck_f;
      cs_p_q <= cs_f;
      mem_q <= mem_d;
      cy_q <= cy_d;
      busy_cnt_q <= busy_cnt_d;
      wr_latch_q <= wr_latch_d;
      pd_q <= pd_d;
      pdn_cnt_q <= pdn_cnt_d;
      rel_cnt_q <= rel_cnt_d;
    end
  end

  assign spi_so = so_q;
  assign spi_so_oe = oe_q;
  assign write_in_progress = busy;
  assign write_enable_latch = wr_latch_q;
  assign deep_power_down = pd_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_cycle_start;
    write_in_progress && !write_enable_latch;
  endsequence
  sequence s_pdn_wait;
    !deep_power_down ##[PDW:PDW] deep_power_down;
  endsequence

  chk_jedec_first: assert property (
    cmd_done && bit_in == fisp_pkg::OP_JEDEC_ID && !busy && !pd_any && rel_cnt_q == 8'h00
    |=> state_q == fisp_pkg::ST_OUT && osh_q == MAKER_CODE)
    else $error("identity read did not start with the maker code");
  chk_busy_no_id: assert property (
    cmd_done && busy && bit_in == fisp_pkg::OP_JEDEC_ID |=> state_q == fisp_pkg::ST_IGN)
    else $error("identity opcode decoded during a busy cycle");
  chk_so_on_fall: assert property (
    $changed(spi_so) |-> $past(sck_fall))
    else $error("serial output changed away from a falling clock");
  chk_cs_ends_read: assert property (
    cs_rise |=> state_q == fisp_pkg::ST_IDLE && !spi_so_oe)
    else $error("deselect did not return to standby");
  chk_erase_start: assert property (
    ev_erase |=> s_cycle_start ##1 write_in_progress [*8])
    else $error("erase start did not raise busy or clear the latch");
  chk_wr_gate: assert property (
    cmd_done && !pd_any && rel_cnt_q == 8'h00 && (security_lock_bit || !wr_latch_q)
    && (bit_in == fisp_pkg::OP_SEC_ERASE || bit_in == fisp_pkg::OP_SEC_PROG)
    |=> state_q == fisp_pkg::ST_IGN)
    else $error("security area command accepted while locked or not enabled");
  chk_prog_start: assert property (
    ev_prog |=> cy_q == fisp_pkg::CY_PROG && busy_cnt_q == 32'(PP_CYCLES))
    else $error("program cycle did not start on deselect");
  chk_sec_wrap: assert property (
    sck_fall && state_q == fisp_pkg::ST_OUT && obit_q == 3'h7 && opc_q == fisp_pkg::OP_SEC_READ
    && addr_q[8:0] == fisp_pkg::SEC_LAST |=> addr_q[8:0] == 9'h000)
    else $error("read address did not wrap to zero");
  chk_pdn_entry: assert property (
    ev_pdn |=> s_pdn_wait)
    else $error("power-down not entered after the entry delay");
  chk_pd_only_rel: assert property (
    cmd_done && pd_q && bit_in != fisp_pkg::OP_RELEASE_ID |=> state_q == fisp_pkg::ST_IGN)
    else $error("command other than release decoded in power-down");
  chk_pdn_busy: assert property (
    cs_rise && busy && opc_q == fisp_pkg::OP_PDN |=> pdn_cnt_q == 8'h00 && $stable(cy_q))
    else $error("power-down accepted during a busy cycle");
  chk_rel_hold: assert property (
    ev_rel |=> !deep_power_down && rel_cnt_q == 8'(fisp_pkg::REL_CYC)
    ##1 (state_q != fisp_pkg::ST_ADDR && state_q != fisp_pkg::ST_OUT) [*8])
    else $error("release did not hold decoding off");
  chk_id_busy: assert property (
    cmd_done && busy && bit_in == fisp_pkg::OP_RELEASE_ID |=> state_q == fisp_pkg::ST_IGN)
    else $error("release opcode decoded during a busy cycle");
endmodule

// File: test/fisp_host_model.sv
`timescale 1ns/1ps
module fisp_host_model #(
  parameter realtime HALF = 40.0
) (
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si,
  input wire logic spi_so
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end
  // odd offset keeps the serial clock out of step with mclk
  task automatic sel();
    #3.7;
    spi_cs_n = 1'b0;
    #(HALF);
  endtask
  // mode 0: drive while low, sample just before the fall that moves the device output
  task automatic xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      spi_si = tx[i];
      #(HALF);
      spi_sck = 1'b1;
      #(HALF - 1.0);
      rx[i] = spi_so;
      #1.0;
      spi_sck = 1'b0;
    end
  endtask
  // area commands carry only the 9-bit byte address
  function automatic logic [23:0] sec_adr(input logic [8:0] b);
    return {15'h0000, b};
  endfunction
  task automatic cmd(input logic [7:0] op, input int nadr, input logic [23:0] a, input int ndum);
    logic [7:0] r;
    sel();
    xb(op, 8, r);
    for (int k = 0; k < nadr; k++) begin
      xb(a[23 - 8 * k -: 8], 8, r);
    end
    for (int k = 0; k < ndum; k++) begin
      xb(8'h00, 8, r);
    end
  endtask
  // released data line must not keep showing its last level
  task automatic desel();
    #(HALF);
    spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #200;
  endtask
endmodule

// File: test/fisp_top_tb.sv
`timescale 1ns/1ps
module fisp_top_tb;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] MTYPE = 8'h33; // arbitrary value
  localparam logic [7:0] CAP = 8'h14; // arbitrary value
  localparam logic [7:0] DEV = 8'h13; // arbitrary value
  localparam logic [127:0] UID = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff; // arbitrary
  logic mclk;
  logic rstn;
  logic spi_cs_n;
  logic spi_sck;
  logic spi_si;
  logic spi_so;
  logic spi_so_oe;
  logic security_lock_bit;
  logic write_in_progress;
  logic write_enable_latch;
  logic deep_power_down;
  logic [7:0] r;
  int miscompares;
  int samples_checked;
  // identity bytes but the unique id keep the design's defaults, so MAKER to DEV must track them
  fisp_top #(.UNIQUE_ID(UID), .PP_CYCLES(1000), .SE_CYCLES(2000)) dut (
    .mclk(mclk),
    .rstn(rstn),
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .spi_si(spi_si),
    .spi_so(spi_so),
    .spi_so_oe(spi_so_oe),
    .security_lock_bit(security_lock_bit),
    .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch),
    .deep_power_down(deep_power_down)
  );
  fisp_host_model host (
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .spi_si(spi_si),
    .spi_so(spi_so)
  );
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // order: output enable, busy, write latch, power-down
  task automatic flags(input logic [3:0] exp);
    chk({4'h0, spi_so_oe, write_in_progress, write_enable_latch, deep_power_down}, {4'h0, exp});
  endtask
  task automatic rdchk(input logic [7:0] exp[$]);
    foreach (exp[i]) begin
      host.xb(8'h00, 8, r);
      chk(r, exp[i]);
    end
  endtask
  task automatic write_enable_command();
    host.cmd(fisp_pkg::OP_WR_ENABLE, 0, 24'h000000, 0);
    host.desel();
    tick(2);
  endtask
  // bounded wait; the flag compare that follows catches a hang
  task automatic wait_idle();
    for (int k = 0; k < 3000; k++) begin
      if (write_in_progress === 1'b0) break;
      tick(1);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    $display("Error at %0t ns: got %h expected %h", $time, 8'h00, 8'h01);
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    security_lock_bit = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    tick(8);
    rstn = 1'b1;
    tick(5);
    flags(4'b0000);
    $display("test reset done");
    host.cmd(fisp_pkg::OP_JEDEC_ID, 0, 24'h000000, 0);
    rdchk('{MAKER, MTYPE, CAP, MAKER});
    flags(4'b1000);
    host.desel();
    flags(4'b0000);
    host.cmd(fisp_pkg::OP_UNIQUE_ID, 3, 24'h000000, 1);
    for (int i = 0; i < 16; i++) begin
      host.xb(8'h00, 8, r);
      chk(r, UID[127 - 8 * i -: 8]);
    end
    host.desel();
    host.cmd(fisp_pkg::OP_RELEASE_ID, 0, 24'h000000, 3);
    rdchk('{DEV, DEV, DEV});
    host.desel();
    $display("test identity done");
    write_enable_command();
    flags(4'b0010);
    host.cmd(fisp_pkg::OP_SEC_ERASE, 3, host.sec_adr(9'h000), 0);
    host.desel();
    tick(2);
    flags(4'b0100);
    host.cmd(fisp_pkg::OP_JEDEC_ID, 0, 24'h000000, 0);
    host.xb(8'h00, 8, r);
    flags(4'b0100);
    host.desel();
    host.cmd(fisp_pkg::OP_PDN, 0, 24'h000000, 0);
    host.desel();
    host.cmd(fisp_pkg::OP_RELEASE_ID, 0, 24'h000000, 0);
    host.desel();
    tick(30);
    flags(4'b0100);
    wait_idle();
    flags(4'b0000);
    $display("test busy done");
    write_enable_command();
    host.cmd(fisp_pkg::OP_SEC_PROG, 3, host.sec_adr(9'h1fe), 0);
    host.xb(8'ha5, 8, r);
    host.xb(8'h3c, 8, r);
    host.xb(8'h0f, 8, r);
    host.desel();
    tick(2);
    flags(4'b0100);
    wait_idle();
    flags(4'b0000);
    host.cmd(fisp_pkg::OP_SEC_READ, 3, host.sec_adr(9'h1fe), 1);
    rdchk('{8'ha5, 8'h3c, 8'h0f, 8'hff});
    host.desel();
    $display("test program done");
    write_enable_command();
    host.cmd(fisp_pkg::OP_SEC_ERASE, 3, host.sec_adr(9'h000), 0);
    host.xb(8'h80, 1, r);
    host.desel();
    tick(2);
    flags(4'b0010);
    security_lock_bit = 1'b1;
    host.cmd(fisp_pkg::OP_SEC_ERASE, 3, host.sec_adr(9'h000), 0);
    host.desel();
    host.cmd(fisp_pkg::OP_SEC_PROG, 3, host.sec_adr(9'h1fe), 0);
    host.xb(8'h00, 8, r);
    host.desel();
    tick(2);
    flags(4'b0010);
    host.cmd(fisp_pkg::OP_SEC_READ, 3, host.sec_adr(9'h1fe), 1);
    rdchk('{8'ha5});
    host.desel();
    security_lock_bit = 1'b0;
    tick(1);
    host.cmd(fisp_pkg::OP_SEC_ERASE, 3, host.sec_adr(9'h000), 0);
    host.desel();
    wait_idle();
    host.cmd(fisp_pkg::OP_SEC_READ, 3, host.sec_adr(9'h1fe), 1);
    rdchk('{8'hff, 8'hff});
    host.desel();
    $display("test erase and lock done");
    host.cmd(fisp_pkg::OP_PDN, 0, 24'h000000, 0);
    host.xb(8'h00, 1, r);
    host.desel();
    tick(20);
    flags(4'b0000);
    host.cmd(fisp_pkg::OP_PDN, 0, 24'h000000, 0);
    host.desel();
    tick(20);
    flags(4'b0001);
    write_enable_command();
    flags(4'b0001);
    host.cmd(fisp_pkg::OP_SEC_READ, 3, host.sec_adr(9'h000), 1);
    host.xb(8'h00, 8, r);
    flags(4'b0001);
    host.desel();
    host.cmd(fisp_pkg::OP_RELEASE_ID, 0, 24'h000000, 0);
    host.desel();
    flags(4'b0000);
    tick(20);
    host.cmd(fisp_pkg::OP_JEDEC_ID, 0, 24'h000000, 0);
    rdchk('{MAKER});
    host.desel();
    $display("test power-down done");
    wrap_up();
  end
endmodule
